// ==== rtl/ctd_regs.svh ====
`ifndef CTD_REGS_SVH
`define CTD_REGS_SVH
// ============================================================
// Software port offsets.
`define CTD_A_CMD          2'h0
`define CTD_A_STAT         2'h1
`define CTD_A_CNT          2'h2
`define CTD_A_CTRL         2'h3
// ============================================================
// Status and control bit positions.
`define CTD_ST_CMD         0
`define CTD_ST_FSYNC       1
`define CTD_ST_BREQ        2
`define CTD_CT_CLR_CMD     0
`define CTD_CT_CLR_FSYNC   1
`define CTD_CT_START       2
// ============================================================
// Reset values.
`define CTD_CNT_RST        8'h00
`define CTD_BYTE_RST       8'h00
// ============================================================
// Timing.
`define CTD_BITS           8
`define CTD_CLK_NS         4
`define CTD_CLK_HZ         250000000
`define CTD_LINK_PERIOD_NS 48
`define CTD_LINK_HALF_CYC  (`CTD_LINK_PERIOD_NS / 2 / `CTD_CLK_NS)
`define CTD_CMD_PERIOD_S   4
`define CTD_CMD_PERIOD_CYC (`CTD_CMD_PERIOD_S * `CTD_CLK_HZ)
`define CTD_REST_CYC       64
`endif

// ==== rtl/ctd_pkg.sv ====
package ctd_pkg;
	// ============================================================
	// One-hot DMA step codes; idle is all zero.
	typedef enum logic [3:0]
	{
		DMA_IDLE = 4'b0000,
		DMA_ADDR = 4'b0001,
		DMA_LOAD = 4'b0010,
		DMA_INC  = 4'b0100,
		DMA_DROP = 4'b1000
	} ctd_dma_t;
	// ============================================================
	// Spacecraft end link states.
	typedef enum logic [2:0]
	{
		SC_IDLE = 3'b000,
		SC_CMD  = 3'b001,
		SC_TLM  = 3'b010,
		SC_TAIL = 3'b011,
		SC_REST = 3'b100
	} ctd_sc_t;
endpackage

// ==== rtl/ctd_link_if.sv ====
interface ctd_link_if;
	logic cmd_en;
	logic cmd_clk;
	logic cmd_data;
	logic frame_sync;
	logic tlm_en;
	logic tlm_clk;
	logic tlm_data;
	modport dev (input cmd_en, cmd_clk, cmd_data, frame_sync, tlm_en, tlm_clk,
		output tlm_data);
	modport sc (output cmd_en, cmd_clk, cmd_data, frame_sync, tlm_en, tlm_clk,
		input tlm_data);
endinterface // ctd_link_if

// ==== rtl/ctd_port_sc.sv ====
`include "ctd_regs.svh"

module ctd_port_sc
	import ctd_pkg::*;
#(
	parameter int CMD_GAP_CYC = `CTD_CMD_PERIOD_CYC,
	parameter int HALF_CYC    = `CTD_LINK_HALF_CYC,
	parameter int REST_CYC    = `CTD_REST_CYC
)
(
	input  wire logic       clk,       // Clock.
	input  wire logic       reset,     // Asynchronous reset.
	input  wire logic       cmd_valid, // Command byte offered.
	input  wire logic [7:0] cmd_byte,  // Command byte.
	output logic            cmd_ready, // Command byte taken.
	input  wire logic       fsync_req, // Issue one frame sync.
	input  wire logic       tlm_go,    // Keep reading telemetry.
	output logic [7:0]      tlm_word,  // Received telemetry word.
	output logic            tlm_valid, // Telemetry word valid.
	input  wire logic       tlm_ready, // Telemetry word taken.
	ctd_link_if.sc          link       // Link to the device.
);
	// ============================================================
	// Link sequencing.
	ctd_sc_t     state, next_state;
	logic [7:0]  phase, next_phase, sr, next_sr, fs_cnt, next_fs_cnt;
	logic [3:0]  bitn, next_bitn;
	logic [31:0] gap, next_gap;
	logic        is_tlm, next_is_tlm, cen, next_cen, ten, next_ten;
	logic        cclk, next_cclk, tclk, next_tclk, cdat, next_cdat;
	logic        fsync, next_fsync, next_cmd_ready, push, td_a, td_b;
	logic        e1_valid, next_e1_valid, next_tlm_valid;
	logic [7:0]  e1, next_e1, next_tlm_word;

	assign link.cmd_en = cen;
	assign link.cmd_clk = cclk;
	assign link.cmd_data = cdat;
	assign link.tlm_en = ten;
	assign link.tlm_clk = tclk;
	assign link.frame_sync = fsync;

	always_comb
	begin
		next_state = state;
		next_phase = phase + 8'h01;
		next_sr = sr;
		next_bitn = bitn;
		next_is_tlm = is_tlm;
		next_cen = cen;
		next_ten = ten;
		next_cclk = cclk;
		next_tclk = tclk;
		next_cdat = cdat;
		push = 1'b0;
		next_gap = (gap != 32'h0) ? gap - 32'h1 : gap;
		next_fs_cnt = (fs_cnt != 8'h00) ? fs_cnt - 8'h01 : fs_cnt;
		if (fsync_req && fs_cnt == 8'h00)
			next_fs_cnt = 8'(2 * HALF_CYC);
		case (state)
			SC_IDLE:
			begin
				next_phase = 8'h00;
				next_bitn = 4'h0;
				if (cmd_valid && cmd_ready)
				begin
					next_state = SC_CMD;
					next_sr = cmd_byte;
					next_cdat = cmd_byte[7];
					next_cen = 1'b1;
					next_is_tlm = 1'b0;
					next_gap = 32'(CMD_GAP_CYC - 1);
				end
				else if (tlm_go && !e1_valid)
				begin
					next_state = SC_TLM;
					next_ten = 1'b1;
					next_is_tlm = 1'b1;
				end
			end
			SC_CMD, SC_TLM:
			begin
				if (phase == 8'(HALF_CYC - 1))
				begin
					next_cclk = !is_tlm;
					next_tclk = is_tlm;
					if (is_tlm)
						next_sr = {sr[6:0], td_b};
				end
				if (phase == 8'(2 * HALF_CYC - 1))
				begin
					next_cclk = 1'b0;
					next_tclk = 1'b0;
					next_phase = 8'h00;
					next_bitn = bitn + 4'h1;
					if (!is_tlm)
					begin
						next_sr = {sr[6:0], 1'b0};
						next_cdat = sr[6];
					end
					if (bitn == 4'(`CTD_BITS - 1))
						next_state = SC_TAIL;
				end
			end
			SC_TAIL:
			begin
				if (phase == 8'(HALF_CYC - 1))
				begin
					next_cen = 1'b0;
					next_ten = 1'b0;
					next_cdat = 1'b0;
					push = is_tlm;
					next_phase = 8'h00;
					next_state = SC_REST;
				end
			end
			SC_REST:
			begin
				if (phase == 8'(REST_CYC - 1))
					next_state = SC_IDLE;
			end
			default:
			begin
				next_state = SC_IDLE;
				next_cen = 1'b0;
				next_ten = 1'b0;
			end
		endcase
		next_fsync = next_fs_cnt != 8'h00;
		next_cmd_ready = next_state == SC_IDLE && next_gap == 32'h0 && !push;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state <= SC_IDLE;
			phase <= 8'h00;
			sr <= `CTD_BYTE_RST;
			bitn <= 4'h0;
			gap <= 32'h0;
			fs_cnt <= 8'h00;
			is_tlm <= 1'b0;
			cen <= 1'b0;
			ten <= 1'b0;
			cclk <= 1'b0;
			tclk <= 1'b0;
			cdat <= 1'b0;
			fsync <= 1'b0;
			cmd_ready <= 1'b0;
			td_a <= 1'b0;
			td_b <= 1'b0;
		end
		else
		begin
			state <= next_state;
			phase <= next_phase;
			sr <= next_sr;
			bitn <= next_bitn;
			gap <= next_gap;
			fs_cnt <= next_fs_cnt;
			is_tlm <= next_is_tlm;
			cen <= next_cen;
			ten <= next_ten;
			cclk <= next_cclk;
			tclk <= next_tclk;
			cdat <= next_cdat;
			fsync <= next_fsync;
			cmd_ready <= next_cmd_ready;
			td_a <= link.tlm_data;
			td_b <= td_a;
		end
	end

	// ============================================================
	// Two-entry word buffer. A new read starts only while the second
	// entry is free, so a stalled consumer halts the link, not data.
	always_comb
	begin
		next_tlm_word = tlm_word;
		next_tlm_valid = tlm_valid;
		next_e1 = e1;
		next_e1_valid = e1_valid;
		if (tlm_valid && tlm_ready)
		begin
			next_tlm_word = e1;
			next_tlm_valid = e1_valid;
			next_e1_valid = 1'b0;
		end
		if (push && !next_tlm_valid)
		begin
			next_tlm_word = sr;
			next_tlm_valid = 1'b1;
		end
		else if (push)
		begin
			next_e1 = sr;
			next_e1_valid = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			tlm_word <= `CTD_BYTE_RST;
			tlm_valid <= 1'b0;
			e1 <= `CTD_BYTE_RST;
			e1_valid <= 1'b0;
		end
		else
		begin
			tlm_word <= next_tlm_word;
			tlm_valid <= next_tlm_valid;
			e1 <= next_e1;
			e1_valid <= next_e1_valid;
		end
	end
endmodule // ctd_port_sc

// ==== rtl/ctd_port_dev.sv ====
`include "ctd_regs.svh"

// ============================================================
// Overview of operation
// - enable window shifts at most eight command bits
// - free or burst clock, capture while enabled
// - enable trailing edge sets command flag
// - host clears flag after reading command
// - command byte readable in parallel form
// - link inputs pass flip-flops before use
// - frame sync sets flag raising interrupt
// - host reloads area once set sent
// - host clears frame flag, starts DMA
// - DMA start sets bus request flag
// - one-hot steps: address, load, count, release
// - loaded word waits for spacecraft indefinitely
// - telemetry enable trailing edge starts DMA
// - word counter readable through own port
// - spacecraft sends one command per period
// - host resets counter before first DMA
module ctd_port_dev
	import ctd_pkg::*;
#(
	parameter int                ADDR_W   = 16,
	parameter logic [ADDR_W-1:0] DMA_BASE = '0
)
(
	input  wire logic       clk,         // Controller clock.
	input  wire logic       reset,       // Asynchronous reset.
	input  wire logic [1:0] sw_addr,     // Software port address.
	input  wire logic [7:0] sw_wdata,    // Software write data.
	input  wire logic       sw_wr,       // Software write strobe.
	input  wire logic       sw_rd,       // Software read strobe.
	output logic [7:0]      sw_rdata,    // Read data, next cycle.
	output logic            bus_req,     // Memory bus request.
	input  wire logic       bus_grant,   // Memory bus granted.
	output logic [ADDR_W-1:0] mem_addr,  // DMA address.
	output logic            mem_addr_oe, // DMA address drive enable.
	input  wire logic [7:0] mem_data,    // Memory read data.
	output logic            irq,         // Frame-sync interrupt.
	ctd_link_if.dev         link         // Spacecraft link.
);
	function automatic logic rose(input logic now, input logic was);
		return now & ~was;
	endfunction

	function automatic logic fell(input logic now, input logic was);
		return ~now & was;
	endfunction

	// ============================================================
	// Input re-registering. The third stage only feeds edge finding.
	logic [5:0] sync_a, sync_b, sync_c;
	logic       cmd_en_s, cmd_clk_rise, cmd_en_fall, fsync_rise;
	logic       tlm_en_s, tlm_clk_rise, tlm_en_fall, ctrl_wr;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sync_a <= 6'h00;
			sync_b <= 6'h00;
			sync_c <= 6'h00;
		end
		else
		begin
			sync_a <= {link.cmd_en, link.cmd_clk, link.cmd_data,
				link.frame_sync, link.tlm_en, link.tlm_clk};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	assign cmd_en_s = sync_b[5];
	assign cmd_clk_rise = rose(sync_b[4], sync_c[4]);
	assign cmd_en_fall = fell(sync_b[5], sync_c[5]);
	assign fsync_rise = rose(sync_b[2], sync_c[2]);
	assign tlm_en_s = sync_b[1];
	assign tlm_clk_rise = rose(sync_b[0], sync_c[0]);
	assign tlm_en_fall = fell(sync_b[1], sync_c[1]);
	assign ctrl_wr = sw_wr && sw_addr == `CTD_A_CTRL;

	// ============================================================
	// Command receiver.
	logic [7:0] command_shift_register, next_command_shift_register;
	logic [7:0] command_input_port, next_command_input_port;
	logic [3:0] cmd_bits, next_cmd_bits;
	logic       command_received_flag, next_command_received_flag;

	always_comb
	begin
		next_command_shift_register = command_shift_register;
		next_command_input_port = command_input_port;
		next_cmd_bits = cmd_bits;
		next_command_received_flag = command_received_flag;
		if (!cmd_en_s)
			next_cmd_bits = 4'h0;
		else if (cmd_clk_rise && cmd_bits != 4'(`CTD_BITS))
		begin
			next_command_shift_register = {command_shift_register[6:0], sync_b[3]};
			next_cmd_bits = cmd_bits + 4'h1;
		end
		if (ctrl_wr && sw_wdata[`CTD_CT_CLR_CMD])
			next_command_received_flag = 1'b0;
		if (cmd_en_fall)
		begin
			next_command_received_flag = 1'b1;
			next_command_input_port = command_shift_register;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			command_shift_register <= `CTD_BYTE_RST;
			command_input_port <= `CTD_BYTE_RST;
			cmd_bits <= 4'h0;
			command_received_flag <= 1'b0;
		end
		else
		begin
			command_shift_register <= next_command_shift_register;
			command_input_port <= next_command_input_port;
			cmd_bits <= next_cmd_bits;
			command_received_flag <= next_command_received_flag;
		end
	end

	// ============================================================
	// Telemetry DMA. The processor is halted while it grants the bus,
	// so software never writes the counter during the steps.
	ctd_dma_t          dma_step_sequencer, next_dma_step_sequencer;
	logic [7:0]        telemetry_shift_register, next_telemetry_shift_register;
	logic [7:0]        dma_word_counter, next_dma_word_counter;
	logic [ADDR_W-1:0] counter_address_driver, next_counter_address_driver;
	logic              bus_request_flag, next_bus_request_flag;
	logic              addr_oe, next_addr_oe, dma_start;
	logic              frame_sync_flag, next_frame_sync_flag;

	assign dma_start = (ctrl_wr && sw_wdata[`CTD_CT_START]) || tlm_en_fall;
	assign link.tlm_data = telemetry_shift_register[7];
	assign bus_req = bus_request_flag;
	assign mem_addr = counter_address_driver;
	assign mem_addr_oe = addr_oe;
	assign irq = frame_sync_flag;

	always_comb
	begin
		next_dma_step_sequencer = dma_step_sequencer;
		next_telemetry_shift_register = telemetry_shift_register;
		next_dma_word_counter = dma_word_counter;
		next_counter_address_driver = counter_address_driver;
		next_bus_request_flag = bus_request_flag;
		next_addr_oe = addr_oe;
		next_frame_sync_flag = frame_sync_flag;
		if (ctrl_wr && sw_wdata[`CTD_CT_CLR_FSYNC])
			next_frame_sync_flag = 1'b0;
		if (fsync_rise)
			next_frame_sync_flag = 1'b1;
		if (sw_wr && sw_addr == `CTD_A_CNT)
			next_dma_word_counter = sw_wdata;
		if (tlm_en_s && tlm_clk_rise)
			next_telemetry_shift_register = {telemetry_shift_register[6:0], 1'b0};
		case (dma_step_sequencer)
			DMA_IDLE:
			begin
				if (bus_request_flag && bus_grant)
				begin
					next_dma_step_sequencer = DMA_ADDR;
					next_addr_oe = 1'b1;
					next_counter_address_driver = DMA_BASE + ADDR_W'(dma_word_counter);
				end
				else if (dma_start && !bus_request_flag)
				begin
					next_bus_request_flag = 1'b1;
				end
			end
			DMA_ADDR:
				next_dma_step_sequencer = DMA_LOAD;
			DMA_LOAD:
			begin
				next_telemetry_shift_register = mem_data;
				next_dma_step_sequencer = DMA_INC;
			end
			DMA_INC:
			begin
				next_dma_word_counter = dma_word_counter + 8'h01;
				next_dma_step_sequencer = DMA_DROP;
			end
			DMA_DROP:
			begin
				next_bus_request_flag = 1'b0;
				next_addr_oe = 1'b0;
				next_dma_step_sequencer = DMA_IDLE;
			end
			default:
			begin
				next_bus_request_flag = 1'b0;
				next_addr_oe = 1'b0;
				next_dma_step_sequencer = DMA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			dma_step_sequencer <= DMA_IDLE;
			telemetry_shift_register <= `CTD_BYTE_RST;
			dma_word_counter <= `CTD_CNT_RST;
			counter_address_driver <= '0;
			bus_request_flag <= 1'b0;
			addr_oe <= 1'b0;
			frame_sync_flag <= 1'b0;
		end
		else
		begin
			dma_step_sequencer <= next_dma_step_sequencer;
			telemetry_shift_register <= next_telemetry_shift_register;
			dma_word_counter <= next_dma_word_counter;
			counter_address_driver <= next_counter_address_driver;
			bus_request_flag <= next_bus_request_flag;
			addr_oe <= next_addr_oe;
			frame_sync_flag <= next_frame_sync_flag;
		end
	end

	// ============================================================
	// Software read port.
	logic [7:0] next_sw_rdata;

	always_comb
	begin
		next_sw_rdata = 8'h00;
		if (sw_rd)
		begin
			case (sw_addr)
				`CTD_A_CMD:
					next_sw_rdata = command_input_port;
				`CTD_A_STAT:
				begin
					next_sw_rdata[`CTD_ST_CMD] = command_received_flag;
					next_sw_rdata[`CTD_ST_FSYNC] = frame_sync_flag;
					next_sw_rdata[`CTD_ST_BREQ] = bus_request_flag;
				end
				`CTD_A_CNT:
					next_sw_rdata = dma_word_counter;
				default:
					next_sw_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			sw_rdata <= 8'h00;
		else
			sw_rdata <= next_sw_rdata;
	end
endmodule // ctd_port_dev

// ==== tb/ctd_link_asserts.sv ====
module ctd_link_asserts
(
	input wire logic clk,        // Controller clock.
	input wire logic reset,      // Asynchronous reset.
	input wire logic cmd_en,     // Command enable.
	input wire logic cmd_clk,    // Command clock.
	input wire logic cmd_data,   // Command data.
	input wire logic frame_sync, // Frame sync.
	input wire logic tlm_en,     // Telemetry enable.
	input wire logic tlm_clk,    // Telemetry clock.
	input wire logic tlm_data    // Telemetry data.
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Pulse counters
	logic [3:0] cmd_pulses;
	logic [3:0] tlm_pulses;
	logic       cmd_clk_q;
	logic       tlm_clk_q;
	logic [3:0] next_cmd_pulses;
	logic [3:0] next_tlm_pulses;

	always_comb
	begin
		next_cmd_pulses = cmd_en ? cmd_pulses + {3'h0, cmd_clk & ~cmd_clk_q} : 4'h0;
		next_tlm_pulses = tlm_en ? tlm_pulses + {3'h0, tlm_clk & ~tlm_clk_q} : 4'h0;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cmd_pulses <= 4'h0;
			tlm_pulses <= 4'h0;
			cmd_clk_q  <= 1'b0;
			tlm_clk_q  <= 1'b0;
		end
		else
		begin
			cmd_pulses <= next_cmd_pulses;
			tlm_pulses <= next_tlm_pulses;
			cmd_clk_q  <= cmd_clk;
			tlm_clk_q  <= tlm_clk;
		end
	end
	// ============================================================
	// Link properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_cmd_clk_gated: assert property (cmd_clk |-> cmd_en)
		else $error("command clock high outside enable");
	a_tlm_clk_gated: assert property (tlm_clk |-> tlm_en)
		else $error("telemetry clock high outside enable");
	a_cmd_bit_count: assert property ($fell(cmd_en) |-> cmd_pulses == 4'h8)
		else $error("command frame without eight clocks");
	a_tlm_bit_count: assert property ($fell(tlm_en) |-> tlm_pulses == 4'h8)
		else $error("telemetry frame without eight clocks");
	a_cmd_data_hold: assert property (cmd_clk && $past(cmd_clk) |-> $stable(cmd_data))
		else $error("command data moved while clock high");
	a_cmd_clk_half: assert property ($rose(cmd_clk) |-> cmd_clk[*6] ##1 !cmd_clk)
		else $error("command clock high phase not six cycles");
	a_fsync_width: assert property ($rose(frame_sync) |->
		frame_sync[*8] ##1 frame_sync[*4] ##1 !frame_sync)
		else $error("frame sync width wrong");
	a_tlm_word_spent: assert property ($fell(tlm_en) |-> !tlm_data)
		else $error("telemetry data not empty after word");
endmodule // ctd_link_asserts

// ==== tb/command_telemetry_dma_port_tb.sv ====
`include "ctd_regs.svh"

module command_telemetry_dma_port_tb;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(n, e, g) \
	samples_checked++; \
	if ((g) !== (e)) begin $display("ERROR %s expected %h seen %h", n, e, g); fail_count++; end

	logic        clk, reset, sw_wr, sw_rd, bus_req, bus_grant, mem_addr_oe, irq;
	logic        cmd_valid, cmd_ready, fsync_req, tlm_go, tlm_valid, tlm_ready;
	logic [1:0]  sw_addr;
	logic [7:0]  sw_wdata, sw_rdata, mem_data, cmd_byte, tlm_word;
	logic [15:0] mem_addr;
	int          fail_count, samples_checked;
	// ============================================================
	// Both ends and the checker
	ctd_link_if link();
	ctd_port_dev ctd_port_dev_inst (.clk(clk), .reset(reset), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.bus_req(bus_req), .bus_grant(bus_grant), .mem_addr(mem_addr),
		.mem_addr_oe(mem_addr_oe), .mem_data(mem_data), .irq(irq), .link(link));
	ctd_port_sc #(.CMD_GAP_CYC(300)) ctd_port_sc_inst (.clk(clk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
		.fsync_req(fsync_req), .tlm_go(tlm_go), .tlm_word(tlm_word),
		.tlm_valid(tlm_valid), .tlm_ready(tlm_ready), .link(link));
	ctd_link_asserts ctd_link_asserts_inst (.clk(clk), .reset(reset),
		.cmd_en(link.cmd_en), .cmd_clk(link.cmd_clk), .cmd_data(link.cmd_data),
		.frame_sync(link.frame_sync), .tlm_en(link.tlm_en), .tlm_clk(link.tlm_clk),
		.tlm_data(link.tlm_data));

	always #2 clk = ~clk;

	// The processor yields the bus one cycle after asking; memory byte is 5a plus address.
	// one fixed set
	always @(posedge clk)
	begin
		bus_grant <= bus_req;
		mem_data <= 8'h5a + mem_addr[7:0];
	end
	// ============================================================
	// Software port tasks
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask

	task automatic chk_rd(input string n, input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1;
		`CHK(n, e, sw_rdata)
	endtask

	task automatic wait_stat(input int b);
		for (int i = 0; i < 600; i++)
		begin
			@(posedge clk);
			sw_addr <= `CTD_A_STAT;
			sw_rd <= 1'b1;
			@(posedge clk);
			sw_rd <= 1'b0;
			#1;
			if (sw_rdata[b] === 1'b1)
				break;
		end
	endtask

	task automatic wait_tlm();
		for (int i = 0; i < 1000 && tlm_valid !== 1'b1; i++)
			@(posedge clk);
	endtask
	// ============================================================
	// Scenarios
	task automatic t_reset();
		chk_rd("status", `CTD_A_STAT, 8'h00);
		chk_rd("counter", `CTD_A_CNT, `CTD_CNT_RST);
		chk_rd("command", `CTD_A_CMD, `CTD_BYTE_RST);
		chk_rd("control", `CTD_A_CTRL, 8'h00);
		`CHK("irq", 1'b0, irq)
		$display("done: reset");
	endtask

	task automatic t_command();
		logic [7:0] b [2] = '{8'hc6, 8'h3b};
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			cmd_valid <= 1'b1;
			cmd_byte <= b[k];
			// The offer must stand at an edge that also sees ready high.
			@(posedge clk);
			for (int i = 0; i < 2000 && cmd_ready !== 1'b1; i++)
				@(posedge clk);
			cmd_valid <= 1'b0;
			wait_stat(`CTD_ST_CMD);
			chk_rd("command", `CTD_A_CMD, b[k]);
			chk_rd("status", `CTD_A_STAT, 8'h01);
			wr(`CTD_A_CTRL, 8'h01);
			chk_rd("status", `CTD_A_STAT, 8'h00);
		end
		$display("done: command");
	endtask

	task automatic t_fsync();
		@(posedge clk);
		fsync_req <= 1'b1;
		@(posedge clk);
		fsync_req <= 1'b0;
		for (int i = 0; i < 40 && irq !== 1'b1; i++)
			@(posedge clk);
		repeat (20) @(posedge clk);
		`CHK("irq", 1'b1, irq)
		chk_rd("status", `CTD_A_STAT, 8'h02);
		wr(`CTD_A_CTRL, 8'h02);
		#1;
		`CHK("irq", 1'b0, irq)
		$display("done: frame sync");
	endtask

	task automatic t_dma();
		wr(`CTD_A_CNT, 8'h03);
		wr(`CTD_A_CTRL, 8'h04);
		#1;
		`CHK("bus_req", 1'b1, bus_req)
		repeat (2) @(posedge clk);
		#1;
		`CHK("addr_oe", 1'b1, mem_addr_oe)
		`CHK("mem_addr", 16'h0003, mem_addr)
		// A second start lands while the steps run and must be dropped.
		wr(`CTD_A_CTRL, 8'h04);
		for (int i = 0; i < 20 && bus_req !== 1'b0; i++)
			@(posedge clk);
		#1;
		`CHK("addr_oe", 1'b0, mem_addr_oe)
		chk_rd("counter", `CTD_A_CNT, 8'h04);
		`CHK("bus_req", 1'b0, bus_req)
		$display("done: dma");
	endtask

	task automatic t_telemetry();
		@(posedge clk);
		tlm_go <= 1'b1;
		wait_tlm();
		repeat (600) @(posedge clk);
		tlm_go <= 1'b0;
		repeat (300) @(posedge clk);
		for (int k = 0; k < 2; k++)
		begin
			#1;
			`CHK("tlm_valid", 1'b1, tlm_valid)
			`CHK("tlm_word", 8'h5d + 8'(k), tlm_word)
			@(posedge clk);
			tlm_ready <= 1'b1;
			@(posedge clk);
			tlm_ready <= 1'b0;
		end
		#1;
		`CHK("tlm_valid", 1'b0, tlm_valid)
		@(posedge clk);
		tlm_go <= 1'b1;
		tlm_ready <= 1'b1;
		wait_tlm();
		// The word leaves at this very edge, so it is taken before the update lands.
		`CHK("tlm_word", 8'h5f, tlm_word)
		@(posedge clk);
		tlm_go <= 1'b0;
		tlm_ready <= 1'b0;
		repeat (300) @(posedge clk);
		chk_rd("counter", `CTD_A_CNT, 8'h07);
		$display("done: telemetry");
	endtask
	// ============================================================
	// Verdict and sequence
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		#200000;
		$display("watchdog expired");
		fail_count++;
		results();
	end

	initial
	begin
		clk = 1'b0;
		reset = 1'b1;
		{sw_wr, sw_rd, cmd_valid, fsync_req, tlm_go, tlm_ready} = '0;
		{sw_addr, sw_wdata, cmd_byte} = '0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_command();
		t_fsync();
		t_dma();
		t_telemetry();
		results();
	end
endmodule // command_telemetry_dma_port_tb
